// file: rtl/psrf_ctrl.sv
`default_nettype none
module psrf_ctrl (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic dev_reset_n_i,
  input wire logic bridge_tied_load_mode_i,
  input wire logic [3:0] pwm_i,
  input wire psrf_pkg::psrf_fault_s fault_i,
  input wire logic [1:0] chan_fault_i,
  input wire logic loop_saturated_i,
  output logic [3:0] high_on_o,
  output logic [3:0] low_on_o,
  output logic [3:0] weak_pd_o,
  output psrf_pkg::psrf_status_s status_o,
  output logic switching_o
);
  typedef enum logic [1:0] {
    PSRF_ST_RESET,
    PSRF_ST_STARTUP,
    PSRF_ST_RUN,
    PSRF_ST_SHUTDOWN
  } psrf_state_e;

  psrf_state_e state_q;
  psrf_state_e state_d;
  logic [psrf_pkg::STARTUP_W-1:0] cnt_q;
  logic [psrf_pkg::STARTUP_W-1:0] cnt_d;
  logic latched_q;
  logic latched_d;
  logic rst_prev_q;
  logic rst_prev_d;
  logic rst_rise;
  logic latch_set;
  logic self_fault;
  psrf_pkg::psrf_status_s status_q;
  psrf_pkg::psrf_status_s status_d;
  psrf_pkg::psrf_hb_e hb_mode [psrf_pkg::NUM_HB];

  assign rst_rise = dev_reset_n_i & ~rst_prev_q;
  // undervoltage clears itself; thermal shutdown and overload latch
  assign self_fault = fault_i.undervoltage;
  assign latch_set = fault_i.overtemp_shutdown | fault_i.overload;

  // the pin is sampled once a clock; no glitch filter is applied
  always_comb
  begin
    rst_prev_d = dev_reset_n_i;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      // a pin already high at release counts as a rising edge
      rst_prev_q <= 1'b0;
    end
    else
    begin
      rst_prev_q <= rst_prev_d;
    end
  end

  // the reset edge wins over a fault still present in that cycle;
  // a lasting fault relatches one edge later
  always_comb
  begin
    latched_d = latched_q;
    if (latch_set)
    begin
      latched_d = 1'b1;
    end
    if (rst_rise)
    begin
      latched_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      latched_q <= 1'b0;
    end
    else
    begin
      latched_q <= latched_d;
    end
  end

  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      PSRF_ST_RESET:
      begin
        cnt_d = '0;
        if (rst_rise)
        begin
          state_d = PSRF_ST_STARTUP;
        end
      end
      PSRF_ST_STARTUP:
      begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == psrf_pkg::STARTUP_W'(psrf_pkg::STARTUP_CYC - 1))
        begin
          state_d = PSRF_ST_RUN;
        end
      end
      PSRF_ST_RUN:
      begin
        if (latched_d || self_fault)
        begin
          state_d = PSRF_ST_SHUTDOWN;
        end
      end
      PSRF_ST_SHUTDOWN:
      begin
        // self-clearing faults restart via the startup sequence
        if (!latched_q && !self_fault)
        begin
          cnt_d = '0;
          state_d = PSRF_ST_STARTUP;
        end
      end
      default:
      begin
        state_d = PSRF_ST_RESET;
      end
    endcase
    if (!dev_reset_n_i)
    begin
      state_d = PSRF_ST_RESET;
      cnt_d = '0;
    end
  end

  always_comb
  begin
    status_d.fault_n = ~(latched_d | self_fault);
    status_d.overtemp_warning_n = ~(fault_i.overtemp_warning
      | fault_i.overtemp_shutdown);
    status_d.near_clipping_n = ~(loop_saturated_i
      && state_q == PSRF_ST_RUN);
    if (!dev_reset_n_i)
    begin
      status_d.fault_n = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_q <= PSRF_ST_RESET;
      cnt_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // status pins idle high: nothing to report while the system is in reset
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      status_q <= '1;
    end
    else
    begin
      status_q <= status_d;
    end
  end

  for (genvar i = 0; i < psrf_pkg::NUM_HB; i++)
  begin : g_hb
    always_comb
    begin
      if (state_q == PSRF_ST_RUN && !chan_fault_i[i/2])
      begin
        hb_mode[i] = psrf_pkg::PSRF_HB_SWITCH;
      end
      else if (state_q == PSRF_ST_RESET && bridge_tied_load_mode_i)
      begin
        hb_mode[i] = psrf_pkg::PSRF_HB_PULLDN;
      end
      else
      begin
        hb_mode[i] = psrf_pkg::PSRF_HB_HIZ;
      end
    end

    psrf_half_bridge u_hb (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .mode_i(hb_mode[i]),
      .pwm_i(pwm_i[i]),
      .high_on_o(high_on_o[i]),
      .low_on_o(low_on_o[i]),
      .weak_pd_o(weak_pd_o[i])
    );
  end

  assign status_o = status_q;
  assign switching_o = (state_q == PSRF_ST_RUN);
endmodule
`default_nettype wire

// file: rtl/psrf_half_bridge.sv
`default_nettype none
module psrf_half_bridge (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire psrf_pkg::psrf_hb_e mode_i,
  input wire logic pwm_i,
  output logic high_on_o,
  output logic low_on_o,
  output logic weak_pd_o
);
  logic high_on_d;
  logic low_on_d;
  logic weak_pd_d;
  logic high_on_q;
  logic low_on_q;
  logic weak_pd_q;

  always_comb
  begin
    high_on_d = 1'b0;
    low_on_d = 1'b0;
    weak_pd_d = 1'b0;
    case (mode_i)
      psrf_pkg::PSRF_HB_PULLDN:
      begin
        weak_pd_d = 1'b1;
      end
      psrf_pkg::PSRF_HB_SWITCH:
      begin
        // inverted stage: a high input pulls the output low
        high_on_d = ~pwm_i;
        low_on_d = pwm_i;
      end
      default:
      begin
        weak_pd_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      high_on_q <= 1'b0;
      low_on_q <= 1'b0;
      weak_pd_q <= 1'b0;
    end
    else
    begin
      high_on_q <= high_on_d;
      low_on_q <= low_on_d;
      weak_pd_q <= weak_pd_d;
    end
  end

  assign high_on_o = high_on_q;
  assign low_on_o = low_on_q;
  assign weak_pd_o = weak_pd_q;
endmodule
`default_nettype wire

// file: rtl/psrf_pkg.sv
`default_nettype none
package psrf_pkg;
  localparam int unsigned NUM_HB = 4;
  localparam int unsigned NUM_CH = 2;
  // startup sequence length before switching, cycles at 25 MHz
  localparam int unsigned STARTUP_NS = 40960;
  localparam int unsigned CLK_NS = 40;
  localparam int unsigned STARTUP_CYC = (STARTUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned STARTUP_W = 11;
  // released-reset guard after a fault edge, for the far side
  localparam int unsigned FAULT_HOLD_MS = 4;

  typedef enum logic [1:0] {
    PSRF_HB_HIZ,
    PSRF_HB_PULLDN,
    PSRF_HB_SWITCH
  } psrf_hb_e;

  typedef struct packed {
    logic overtemp_shutdown;
    logic overload;
    logic undervoltage;
    logic overtemp_warning;
  } psrf_fault_s;

  typedef struct packed {
    logic fault_n;
    logic overtemp_warning_n;
    logic near_clipping_n;
  } psrf_status_s;
endpackage
`default_nettype wire

// file: tb/psrf_ctrl_props.sv
`default_nettype none
module psrf_ctrl_props (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic dev_reset_n_i,
  input wire logic bridge_tied_load_mode_i,
  input wire logic loop_saturated_i,
  input wire logic switching_o,
  input wire logic [1:0] chan_fault_i,
  input wire logic [3:0] pwm_i,
  input wire logic [3:0] high_on_o,
  input wire logic [3:0] low_on_o,
  input wire logic [3:0] weak_pd_o,
  input wire psrf_pkg::psrf_fault_s fault_i,
  input wire psrf_pkg::psrf_status_s status_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire logic r = dev_reset_n_i;
  logic [10:0] up_q;
  // saturates so a long run never wraps back under the startup bound
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
    if (!rst_n_i)
      up_q <= 11'h0;
    else
      up_q <= !r ? 11'h0 : up_q + {10'h0, ~&up_q};
  property p_off; (!r)[*2] |=> (high_on_o | low_on_o) == 4'h0; endproperty
  a_off: assert property (p_off) else $error("fet on");
  property p_pd;
    (!r && bridge_tied_load_mode_i)[*3] |-> weak_pd_o == 4'hf;
  endproperty
  a_pd: assert property (p_pd) else $error("pulldown off");
  property p_hide; !r |=> status_o.fault_n; endproperty
  a_hide: assert property (p_hide) else $error("flag low");
  property p_wait; up_q < 11'h400 |-> !switching_o; endproperty
  a_wait: assert property (p_wait) else $error("early run");
  property p_near_clipping_n;
    switching_o && loop_saturated_i |=> !status_o.near_clipping_n;
  endproperty
  a_near_clipping_n: assert property (p_near_clipping_n) else $error("no near_clipping_n");
  property p_noclip; !loop_saturated_i |=> status_o.near_clipping_n; endproperty
  a_noclip: assert property (p_noclip) else $error("near_clipping_n");
  property p_inv;
    switching_o && chan_fault_i == 2'h0 && fault_i[3:1] == 3'h0
      |=> low_on_o == $past(pwm_i) && high_on_o == ~$past(pwm_i);
  endproperty
  a_inv: assert property (p_inv) else $error("bad pwm");
  property p_latch;
    switching_o && r && fault_i.overload
      |=> !status_o.fault_n ##1 (high_on_o | low_on_o) == 4'h0;
  endproperty
  a_latch: assert property (p_latch) else $error("no stop");
endmodule
bind psrf_ctrl psrf_ctrl_props u_psrf_ctrl_props (.*);
`default_nettype wire

// file: tb/psrf_mcu_model.sv
`default_nettype none
module psrf_mcu_model #(parameter int HOLD = 64) (
  input wire logic clk_i,
  input wire logic hold_i,
  input wire psrf_pkg::psrf_status_s status_i,
  output logic dev_reset_n_o = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic seen_q = 1'b1;
  int wait_q = 0;
  // guard scaled down to HOLD cycles so the run stays short
  always @(negedge clk_i)
  begin
    seen_q <= status_i.fault_n;
    if (seen_q && !status_i.fault_n)
      wait_q <= HOLD;
    else if (wait_q > 0)
      wait_q <= wait_q - 1;
    if (hold_i)
      dev_reset_n_o <= 1'b0;
    else if (wait_q == 0 && status_i.overtemp_warning_n)
      dev_reset_n_o <= 1'b1;
  end
endmodule
`default_nettype wire

// file: tb/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i = 0, rst_n_i = 0, hold = 1, dev_reset_n_i, switching_o;
  logic bridge_tied_load_mode_i = 0, loop_saturated_i = 0;
  logic [3:0] pwm_i = 0, high_on_o, low_on_o, weak_pd_o;
  logic [1:0] chan_fault_i = 0;
  psrf_pkg::psrf_fault_s fault_i = '0;
  psrf_pkg::psrf_status_s status_o;
  int miscompares = 0, checked = 0, cyc = 0, n;
  always #20 sys_clk_i = ~sys_clk_i;
  psrf_ctrl u_psrf_ctrl (.*);
  psrf_mcu_model u_psrf_mcu_model (.clk_i(sys_clk_i), .hold_i(hold),
    .status_i(status_o), .dev_reset_n_o(dev_reset_n_i));
  task automatic chk(logic [11:0] s, logic [11:0] e);
    checked++;
    if (s !== e)
    begin
      miscompares++;
      $display("Error %0t got %h exp %h", $time, s, e);
    end
  endtask
  task complete_run;
    $display("checks %0d errors %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  function automatic logic [3:0] en(logic [1:0] c);
    return {{2{~c[1]}}, {2{~c[0]}}};
  endfunction
  task w(int k);
    repeat (k) @(negedge sys_clk_i);
  endtask
  always @(posedge sys_clk_i)
    if (++cyc == 20000)
    begin
      miscompares++;
      complete_run;
    end
  initial
  begin
    n = $urandom(32'hc2eddc1f);
    w(16);
    rst_n_i = 1;
    for (int m = 0; m < 2; m++)
    begin
      hold = 1;
      bridge_tied_load_mode_i = m[0];
      fault_i.overload = 1;
      w(4);
      chk(high_on_o | low_on_o, 12'h0);
      chk(weak_pd_o, {4{m[0]}});
      chk(status_o.fault_n, 12'h1);
      fault_i = '0;
      hold = 0;
      @(posedge dev_reset_n_i);
      w(1);
      for (n = 0; !switching_o && n < 2000; n++) w(1);
      chk(12'(n), 12'(psrf_pkg::STARTUP_CYC));
      repeat (300)
      begin
        w(1);
        chk(low_on_o, pwm_i & en(chan_fault_i));
        chk(high_on_o, ~pwm_i & en(chan_fault_i));
        chk(status_o, {1'b1, ~fault_i[0], ~loop_saturated_i});
        pwm_i = 4'($urandom);
        chan_fault_i = $urandom % 6 == 0 ? 2'($urandom) : 2'h0;
        // back off while the stage reports near clipping
        loop_saturated_i = status_o.near_clipping_n
          ? 1'($urandom) : 1'b0;
        fault_i[0] = 1'($urandom);
      end
      // undervoltage stops switching, then restarts with no reset toggle
      w(1);
      fault_i = 4'h2;
      loop_saturated_i = 0;
      w(1);
      chk(status_o, 12'h3);
      fault_i = '0;
      w(1);
      chk(high_on_o | low_on_o, 12'h0);
      for (n = 0; !switching_o && n < 2000; n++) w(1);
      chk(12'(n), 12'(psrf_pkg::STARTUP_CYC));
      w(1);
      fault_i = m ? 4'h4 : 4'h8;
      w(1);
      chk(status_o, {1'b0, m[0], 1'b1});
      fault_i = '0;
      w(3);
      chk(high_on_o | low_on_o, 12'h0);
      chk(status_o, 12'h3);
    end
    complete_run;
  end
endmodule
`default_nettype wire
